/* ebpi_regs.svh */
// register offsets, field positions, reset values and timing counts of the pin interface
`ifndef EBPI_REGS_SVH
`define EBPI_REGS_SVH

// byte offsets of the register words
`define EBPI_OFS_CFG 8'h00
`define EBPI_OFS_BUSCTL 8'h04
`define EBPI_OFS_ADDR 8'h08
`define EBPI_OFS_WDATA 8'h0c
`define EBPI_OFS_CMD 8'h10
`define EBPI_OFS_STAT 8'h14
`define EBPI_OFS_RDATA 8'h18

// field positions
`define EBPI_CFG_GATE_BIT 0
`define EBPI_STAT_DONE_BIT 1

// reset values
`define EBPI_CFG_GATE_RST 1'b1
`define EBPI_BUSCTL_RST 5'h00

// speed mode codes of the io side clock strap
`define EBPI_SPD_FULL 2'h0
`define EBPI_SPD_HALF 2'h1
`define EBPI_SPD_THIRD 2'h2
`define EBPI_SPD_QUARTER 2'h3

// bus width codes
`define EBPI_W32 2'h0
`define EBPI_W16 2'h1
`define EBPI_W8 2'h2

// default cycle counts on the internal bus clock
`define EBPI_SETUP_CYC 1
`define EBPI_STROBE_CYC 2

`endif

/* ebpi_pkg.sv */
// types and lane decoding shared by the external bus pin interface
package ebpi_pkg;

  typedef struct packed {
    logic ack_en;
    logic bwe_val;
    logic bwe_sel;
    logic [1:0] width;
  } ebpi_busctl_type;

  typedef struct packed {
    logic [3:0] lanes;
    logic write;
    logic [2:0] cs;
  } ebpi_ctl_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    ebpi_ctl_type ctl;
  } ebpi_cmd_type;

  typedef struct packed {
    logic ale_n;
    logic [7:0] cs_n;
    logic oe_n;
    logic we_n;
    logic [3:0] lane_n;
    logic [15:0] addr;
    logic [31:0] data;
    logic data_oe;
    logic isolate;
  } ebpi_pins_type;

  typedef enum logic [2:0] {S_IDLE, S_LATCH, S_SETUP, S_STROBE, S_HOLD} ebpi_state_type;

  // all strobes idle, bus separated
  localparam ebpi_pins_type EBPI_PINS_IDLE = '{ale_n: 1'b1, cs_n: 8'hff, oe_n: 1'b1,
    we_n: 1'b1, lane_n: 4'hf, addr: 16'h0000, data: 32'h00000000, data_oe: 1'b0,
    isolate: 1'b1};

  // lane i carries data bits 8*i+7 to 8*i; narrow buses keep only the low lanes
  function automatic logic [3:0] lane_mask(input logic [1:0] width, input logic [3:0] lanes);
    lane_mask = lanes;
    if (width == 2'h1)
      lane_mask = {2'b00, lanes[1:0]};
    else if (width == 2'h2)
      lane_mask = {3'b000, lanes[0]};
  endfunction

endpackage

/* ebpi_clkdiv.sv */
// io side clock divider with gate
`timescale 1ns/1ps
`include "ebpi_regs.svh"
module ebpi_clkdiv
  import ebpi_pkg::*;
(
  input wire logic clk_in, // internal bus clock
  input wire logic rst_n_in, // synchronised reset, active low
  input wire logic [1:0] speed_in, // captured speed mode
  input wire logic gate_in, // 1 lets the clock run
  output logic io_clk_out // io side clock pin
);

  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic div_r;
  logic div_nxt;
  logic [1:0] half;

  // count 0..speed and keep the output high while the count is below 1 at half speed, below 2 otherwise
  always_comb
  begin
    half = (speed_in == `EBPI_SPD_HALF) ? 2'h1 : 2'h2;
    cnt_nxt = (cnt_r >= speed_in) ? 2'h0 : cnt_r + 2'h1;
    div_nxt = (cnt_nxt < half);
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r <= 2'h0;
      div_r <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
    end
  end

  // full speed passes the clock itself; the gate bit must only change while no
  // device relies on the clock, the mux is not glitch free
  assign io_clk_out = !gate_in ? 1'b1 :
    ((speed_in == `EBPI_SPD_FULL) ? clk_in : div_r);

  a_gate_high: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !gate_in |-> io_clk_out)
    else $error("gated io clock not high");

  a_quarter_duty: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (speed_in == `EBPI_SPD_QUARTER) && $rose(div_r) |-> div_r[*2] ##1 !div_r[*2] ##1 div_r)
    else $error("quarter speed clock period wrong");

  a_half_duty: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (speed_in == `EBPI_SPD_HALF) && $rose(div_r) |=> !div_r ##1 div_r)
    else $error("half speed clock period wrong");

endmodule

/* ebpi_top.sv */
// external bus pin interface: ahb-lite registers and link side bus cycle sequencer
`timescale 1ns/1ps
`include "ebpi_regs.svh"
// Function
// - the io side clock runs at the internal bus clock or one half, third or quarter of it.
// - two strap levels caught after reset release pick the io clock speed mode.
// - with the clock gate bit cleared the io side clock pin stays high.
// - an active low latch strobe marks the high address half on the shared address pins.
// - eight active low chip selects, one per external region, frame each bus cycle.
// - an active low output enable lets the selected device drive data during reads.
// - an active low static write strobe marks write cycles.
// - in byte enable mode the lane outputs mark valid lanes for reads and writes.
// - in byte write mode the lane outputs act only during write strobes.
// - a 16-bit bus uses lanes 1 and 0 only, an 8-bit bus lane 0 only.
// - lane 3 carries bits 31..24, lane 2 23..16, lane 1 15..8, lane 0 7..0.
// - lane mode follows a strap level unless the bus control register overrides it.
// - the isolate output is high to separate the bus and low to connect it.
module ebpi_top
  import ebpi_pkg::*;
#(
  parameter int SETUP_CYC = `EBPI_SETUP_CYC,
  parameter int STROBE_CYC = `EBPI_STROBE_CYC
)
(
  input wire logic CLK_IN, // register clock
  input wire logic RESETN_IN, // async reset, active low
  input wire logic HSEL_IN, // ahb slave select
  input wire logic [31:0] HADDR_IN, // ahb address
  input wire logic [1:0] HTRANS_IN, // ahb transfer type
  input wire logic HWRITE_IN, // ahb write
  input wire logic [2:0] HSIZE_IN, // ahb size, word only
  input wire logic [31:0] HWDATA_IN, // ahb write data
  input wire logic HREADY_IN, // ahb bus ready
  output logic [31:0] HRDATA_OUT, // ahb read data
  output logic HREADYOUT_OUT, // ahb slave ready
  output logic HRESP_OUT, // ahb response, always okay
  input wire logic LINK_CLK_IN, // internal bus clock of the pin side
  input wire logic [1:0] STRAP_SPEED_IN, // speed mode strap
  input wire logic STRAP_BWE_IN, // byte write mode strap
  output logic IO_CLK_OUT, // io side clock
  output logic ADDRESS_LATCH_STROBE_N_OUT, // high address latch strobe
  output logic [15:0] ADDR_OUT, // multiplexed address
  output logic [7:0] CHIP_SEL_N_OUT, // chip selects
  output logic OUT_EN_N_OUT, // output enable
  output logic STATIC_WRITE_STROBE_N_OUT, // write strobe
  output logic [3:0] BYTE_LANE_N_OUT, // byte lane valid or write strobes
  input wire logic [31:0] DATA_IN, // data pins in
  output logic [31:0] DATA_OUT, // data pins out
  output logic DATA_OE_OUT, // data pins driven
  input wire logic ACK_N_IN, // acknowledge, pulled up
  output logic BUS_ISOLATE_OUT // bus isolation buffers
);

  localparam logic [3:0] SETUP_LAST = 4'(SETUP_CYC - 1);
  localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);

  // strobe needs two cycles so the synchronised data sample lies inside it
  if (SETUP_CYC < 1 || SETUP_CYC > 16 || STROBE_CYC < 2 || STROBE_CYC > 16)
  begin : g_bad_cycles
    $error("ebpi_top: cycle counts out of range");
  end

  // ----------------------------------------------------------------
  // register side
  // ----------------------------------------------------------------
  logic ahb_pend_r, ahb_pend_nxt;
  logic ahb_wr_r, ahb_wr_nxt;
  logic [7:0] ahb_ofs_r, ahb_ofs_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic cfg_gate_r, cfg_gate_nxt;
  ebpi_busctl_type busctl_r, busctl_nxt;
  ebpi_cmd_type cmd_r, cmd_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  logic req_tgl_r, req_tgl_nxt;
  logic done_s1_r, done_s2_r, done_s3_r;
  logic [2:0] rb_s1_r, rb_s2_r;
  logic done_edge;
  logic ahb_take;
  logic [31:0] lrdata_r, lrdata_nxt;
  logic done_tgl_r, done_tgl_nxt;
  logic [1:0] spd_r, spd_nxt;
  logic bwe_strap_r, bwe_strap_nxt;

  assign ahb_take = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  assign done_edge = done_s2_r ^ done_s3_r;

  // link done toggle and strap readback cross by two flops
  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
      done_s3_r <= 1'b0;
      rb_s1_r <= 3'h0;
      rb_s2_r <= 3'h0;
    end
    else
    begin
      done_s1_r <= done_tgl_r;
      done_s2_r <= done_s1_r;
      done_s3_r <= done_s2_r;
      rb_s1_r <= {bwe_strap_r, spd_r};
      rb_s2_r <= rb_s1_r;
    end
  end

  // every transfer takes one wait state so read data comes from a flop
  always_comb
  begin
    ahb_pend_nxt = 1'b0;
    ahb_wr_nxt = ahb_wr_r;
    ahb_ofs_nxt = ahb_ofs_r;
    hrdata_nxt = hrdata_r;
    cfg_gate_nxt = cfg_gate_r;
    busctl_nxt = busctl_r;
    cmd_nxt = cmd_r;
    busy_nxt = busy_r;
    done_nxt = done_r;
    req_tgl_nxt = req_tgl_r;
    if (ahb_take)
    begin
      ahb_pend_nxt = 1'b1;
      ahb_wr_nxt = HWRITE_IN;
      ahb_ofs_nxt = HADDR_IN[7:0];
    end
    if (ahb_pend_r && !ahb_wr_r)
    begin
      case (ahb_ofs_r)
        `EBPI_OFS_CFG: hrdata_nxt = {28'h0000000, rb_s2_r, cfg_gate_r};
        `EBPI_OFS_BUSCTL: hrdata_nxt = {27'h0, busctl_r};
        `EBPI_OFS_ADDR: hrdata_nxt = cmd_r.addr;
        `EBPI_OFS_WDATA: hrdata_nxt = cmd_r.wdata;
        `EBPI_OFS_CMD: hrdata_nxt = {24'h000000, cmd_r.ctl};
        `EBPI_OFS_STAT: hrdata_nxt = {30'h0, done_r, busy_r};
        `EBPI_OFS_RDATA: hrdata_nxt = lrdata_r;
        default: hrdata_nxt = 32'h00000000;
      endcase
    end
    // command words are refused while a cycle runs, they feed the link side
    if (ahb_pend_r && ahb_wr_r)
    begin
      case (ahb_ofs_r)
        `EBPI_OFS_CFG: cfg_gate_nxt = HWDATA_IN[`EBPI_CFG_GATE_BIT];
        `EBPI_OFS_BUSCTL: busctl_nxt = ebpi_busctl_type'(HWDATA_IN[4:0]);
        `EBPI_OFS_ADDR: cmd_nxt.addr = busy_r ? cmd_r.addr : HWDATA_IN;
        `EBPI_OFS_WDATA: cmd_nxt.wdata = busy_r ? cmd_r.wdata : HWDATA_IN;
        `EBPI_OFS_CMD:
        begin
          if (!busy_r)
          begin
            cmd_nxt.ctl = ebpi_ctl_type'(HWDATA_IN[7:0]);
            busy_nxt = 1'b1;
            req_tgl_nxt = ~req_tgl_r;
          end
        end
        `EBPI_OFS_STAT:
        begin
          if (HWDATA_IN[`EBPI_STAT_DONE_BIT])
            done_nxt = 1'b0;
        end
        default: ;
      endcase
    end
    // completion wins over a clear in the same cycle
    if (done_edge)
    begin
      busy_nxt = 1'b0;
      done_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      ahb_pend_r <= 1'b0;
      ahb_wr_r <= 1'b0;
      ahb_ofs_r <= 8'h00;
      hrdata_r <= 32'h00000000;
      cfg_gate_r <= `EBPI_CFG_GATE_RST;
      busctl_r <= `EBPI_BUSCTL_RST;
      cmd_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      req_tgl_r <= 1'b0;
    end
    else
    begin
      ahb_pend_r <= ahb_pend_nxt;
      ahb_wr_r <= ahb_wr_nxt;
      ahb_ofs_r <= ahb_ofs_nxt;
      hrdata_r <= hrdata_nxt;
      cfg_gate_r <= cfg_gate_nxt;
      busctl_r <= busctl_nxt;
      cmd_r <= cmd_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      req_tgl_r <= req_tgl_nxt;
    end
  end

  assign HRDATA_OUT = hrdata_r;
  assign HREADYOUT_OUT = !ahb_pend_r;
  assign HRESP_OUT = 1'b0;

  a_ahb_wait: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    ahb_take |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT)
    else $error("ahb wait state not exactly one");

  a_done_sets: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    done_edge |=> done_r && !busy_r)
    else $error("completion lost");

  // ----------------------------------------------------------------
  // link side synchronisers
  // ----------------------------------------------------------------
  logic lrst_s1_r, lrst_n_r;
  logic req_s1_r, req_s2_r, req_s3_r;
  logic gate_s1_r, gate_l;
  ebpi_busctl_type bc_s1_r, busctl_l;
  logic [2:0] strap_s1_r, strap_s2_r;
  logic ack_s1_r, ack_s2_r;
  logic [31:0] data_s1_r, data_s2_r;

  // reset released on the link clock so no flop sees a half release
  always_ff @(posedge LINK_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      lrst_s1_r <= 1'b0;
      lrst_n_r <= 1'b0;
    end
    else
    begin
      lrst_s1_r <= 1'b1;
      lrst_n_r <= lrst_s1_r;
    end
  end

  // configuration is quasi static: change it only while no cycle runs
  always_ff @(posedge LINK_CLK_IN or negedge lrst_n_r)
  begin
    if (!lrst_n_r)
    begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
      gate_s1_r <= `EBPI_CFG_GATE_RST;
      gate_l <= `EBPI_CFG_GATE_RST;
      bc_s1_r <= `EBPI_BUSCTL_RST;
      busctl_l <= `EBPI_BUSCTL_RST;
      strap_s1_r <= 3'h0;
      strap_s2_r <= 3'h0;
      ack_s1_r <= 1'b1;
      ack_s2_r <= 1'b1;
      data_s1_r <= 32'h00000000;
      data_s2_r <= 32'h00000000;
    end
    else
    begin
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      gate_s1_r <= cfg_gate_r;
      gate_l <= gate_s1_r;
      bc_s1_r <= busctl_r;
      busctl_l <= bc_s1_r;
      strap_s1_r <= {STRAP_BWE_IN, STRAP_SPEED_IN};
      strap_s2_r <= strap_s1_r;
      ack_s1_r <= ACK_N_IN;
      ack_s2_r <= ack_s1_r;
      data_s1_r <= DATA_IN;
      data_s2_r <= data_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  logic [1:0] strap_cnt_r, strap_cnt_nxt;
  logic strap_done;

  assign strap_done = (strap_cnt_r == 2'h3);

  // straps are caught once the synchroniser holds post reset levels
  always_comb
  begin
    strap_cnt_nxt = strap_done ? strap_cnt_r : strap_cnt_r + 2'h1;
    spd_nxt = spd_r;
    bwe_strap_nxt = bwe_strap_r;
    if (strap_cnt_r == 2'h2)
    begin
      spd_nxt = strap_s2_r[1:0];
      bwe_strap_nxt = strap_s2_r[2];
    end
  end

  always_ff @(posedge LINK_CLK_IN or negedge lrst_n_r)
  begin
    if (!lrst_n_r)
    begin
      strap_cnt_r <= 2'h0;
      spd_r <= `EBPI_SPD_FULL;
      bwe_strap_r <= 1'b0;
    end
    else
    begin
      strap_cnt_r <= strap_cnt_nxt;
      spd_r <= spd_nxt;
      bwe_strap_r <= bwe_strap_nxt;
    end
  end

  ebpi_clkdiv u_clkdiv (
    .clk_in(LINK_CLK_IN),
    .rst_n_in(lrst_n_r),
    .speed_in(spd_r),
    .gate_in(gate_l),
    .io_clk_out(IO_CLK_OUT)
  );

  // ----------------------------------------------------------------
  // bus cycle sequencer
  // ----------------------------------------------------------------
  ebpi_state_type state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  ebpi_cmd_type lcmd_r, lcmd_nxt;
  ebpi_pins_type pins_r, pins_nxt;
  logic bwe_mode;
  logic [3:0] lanes_n;

  assign bwe_mode = busctl_l.bwe_sel ? busctl_l.bwe_val : bwe_strap_r;

  // cmd_r is stable from before the request toggle until done, so it is read here
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    lcmd_nxt = lcmd_r;
    lrdata_nxt = lrdata_r;
    done_tgl_nxt = done_tgl_r;
    case (state_r)
      S_IDLE:
      begin
        if (req_s2_r ^ req_s3_r)
        begin
          lcmd_nxt = cmd_r;
          state_nxt = S_LATCH;
        end
      end
      S_LATCH:
      begin
        state_nxt = S_SETUP;
        cnt_nxt = 4'h0;
      end
      S_SETUP:
      begin
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == SETUP_LAST)
        begin
          state_nxt = S_STROBE;
          cnt_nxt = 4'h0;
        end
      end
      S_STROBE:
      begin
        if (cnt_r != STROBE_LAST)
          cnt_nxt = cnt_r + 4'h1;
        else if (!busctl_l.ack_en || !ack_s2_r)
          state_nxt = S_HOLD;
      end
      S_HOLD:
      begin
        if (!lcmd_r.ctl.write)
          lrdata_nxt = data_s2_r;
        done_tgl_nxt = ~done_tgl_r;
        state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
    // lanes worked out here so no net loops back into this process
    lanes_n = ~lane_mask(busctl_l.width, lcmd_nxt.ctl.lanes);
    // pins follow the next state so every pin comes straight from a flop
    pins_nxt = EBPI_PINS_IDLE;
    pins_nxt.isolate = (state_nxt == S_IDLE);
    case (state_nxt)
      S_LATCH:
      begin
        pins_nxt.ale_n = 1'b0;
        pins_nxt.addr = lcmd_nxt.addr[31:16];
      end
      S_SETUP, S_STROBE, S_HOLD:
      begin
        pins_nxt.addr = lcmd_nxt.addr[15:0];
        pins_nxt.cs_n = ~(8'h01 << lcmd_nxt.ctl.cs);
        pins_nxt.data_oe = lcmd_nxt.ctl.write;
        pins_nxt.data = lcmd_nxt.wdata;
        if (!bwe_mode)
          pins_nxt.lane_n = lanes_n;
        if (state_nxt == S_STROBE)
        begin
          pins_nxt.oe_n = lcmd_nxt.ctl.write;
          pins_nxt.we_n = !lcmd_nxt.ctl.write;
          if (bwe_mode && lcmd_nxt.ctl.write)
            pins_nxt.lane_n = lanes_n;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge LINK_CLK_IN or negedge lrst_n_r)
  begin
    if (!lrst_n_r)
    begin
      state_r <= S_IDLE;
      cnt_r <= 4'h0;
      lcmd_r <= '0;
      pins_r <= EBPI_PINS_IDLE;
      lrdata_r <= 32'h00000000;
      done_tgl_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      lcmd_r <= lcmd_nxt;
      pins_r <= pins_nxt;
      lrdata_r <= lrdata_nxt;
      done_tgl_r <= done_tgl_nxt;
    end
  end

  assign ADDRESS_LATCH_STROBE_N_OUT = pins_r.ale_n;
  assign ADDR_OUT = pins_r.addr;
  assign CHIP_SEL_N_OUT = pins_r.cs_n;
  assign OUT_EN_N_OUT = pins_r.oe_n;
  assign STATIC_WRITE_STROBE_N_OUT = pins_r.we_n;
  assign BYTE_LANE_N_OUT = pins_r.lane_n;
  assign DATA_OUT = pins_r.data;
  assign DATA_OE_OUT = pins_r.data_oe;
  assign BUS_ISOLATE_OUT = pins_r.isolate;

  // ----------------------------------------------------------------
  // link side checks
  // ----------------------------------------------------------------
  sequence s_latch_then_select;
    &pins_r.cs_n ##1 (pins_r.ale_n && !(&pins_r.cs_n));
  endsequence

  a_strap_hold: assert property (@(posedge LINK_CLK_IN) disable iff (!lrst_n_r)
    strap_done |=> $stable(spd_r) && $stable(bwe_strap_r))
    else $error("strap levels changed after capture");

  a_latch_order: assert property (@(posedge LINK_CLK_IN) disable iff (!lrst_n_r)
    $fell(pins_r.ale_n) |-> s_latch_then_select)
    else $error("latch strobe not followed by chip select");

  a_cs_onehot: assert property (@(posedge LINK_CLK_IN) disable iff (!lrst_n_r)
    !(&pins_r.cs_n) |-> $onehot(~pins_r.cs_n) && pins_r.ale_n)
    else $error("chip selects not one hot");

  a_oe_read: assert property (@(posedge LINK_CLK_IN) disable iff (!lrst_n_r)
    !pins_r.oe_n |-> !lcmd_r.ctl.write && !pins_r.data_oe && state_r == S_STROBE)
    else $error("output enable outside a read strobe");

  a_we_write: assert property (@(posedge LINK_CLK_IN) disable iff (!lrst_n_r)
    !pins_r.we_n |-> lcmd_r.ctl.write && pins_r.data_oe && pins_r.oe_n)
    else $error("write strobe outside a write");

  a_be_lanes: assert property (@(posedge LINK_CLK_IN) disable iff (!lrst_n_r)
    state_r == S_STROBE && !bwe_mode && $stable(busctl_l)
    |-> pins_r.lane_n == ~lane_mask(busctl_l.width, lcmd_r.ctl.lanes))
    else $error("byte enables wrong");

  a_bwe_read_idle: assert property (@(posedge LINK_CLK_IN) disable iff (!lrst_n_r)
    bwe_mode && $stable(bwe_mode) && (!lcmd_r.ctl.write || state_r != S_STROBE)
    |-> &pins_r.lane_n)
    else $error("byte write strobe outside a write strobe");

  a_width_unused: assert property (@(posedge LINK_CLK_IN) disable iff (!lrst_n_r)
    busctl_l.width == `EBPI_W16 && $stable(busctl_l) |-> &pins_r.lane_n[3:2])
    else $error("upper lanes used on a 16-bit bus");

  a_isolate: assert property (@(posedge LINK_CLK_IN) disable iff (!lrst_n_r)
    pins_r.isolate == (state_r == S_IDLE))
    else $error("isolate output does not match bus activity");

  a_ack_stretch: assert property (@(posedge LINK_CLK_IN) disable iff (!lrst_n_r)
    state_r == S_STROBE && cnt_r == STROBE_LAST && busctl_l.ack_en && ack_s2_r
    |=> state_r == S_STROBE && !pins_r.cs_n[lcmd_r.ctl.cs])
    else $error("strobe ended without acknowledge");

endmodule

/* ebpi_mem_model.sv */
// partner model: external memory or i/o device on the pin side
`timescale 1ns/1ps
module ebpi_mem_model
  import ebpi_pkg::*;
(
  input wire logic link_clk_in, // internal bus clock of the pin side
  input wire logic [7:0] cs_n_in, // chip selects
  input wire logic oe_n_in, // output enable
  input wire logic we_n_in, // static write strobe
  input wire logic [31:0] wdata_in, // data driven by the interface
  input wire logic [7:0] ack_dly_in, // strobe cycles before acknowledge
  output logic [31:0] rdata_out, // data from the device toward the interface
  output logic ack_n_out // acknowledge, pulled up when released
);
  // ----------------------------------------
  // storage and pin behaviour
  // ----------------------------------------
  logic [31:0] mem_r [8];
  logic [31:0] junk_r = 32'h5a3c96e1;
  logic [7:0] n_r = 8'h00;
  logic [2:0] sel;
  // one region per chip select
  always_comb
  begin
    sel = 3'h0;
    for (int i = 0; i < 8; i++)
      if (!cs_n_in[i])
        sel = 3'(i);
  end
  // released data lines wander, so a stale value can never pass for a read
  always @(posedge link_clk_in)
  begin
    if (!we_n_in)
      mem_r[sel] <= wdata_in;
    n_r <= (!oe_n_in || !we_n_in) ? n_r + 8'h01 : 8'h00;
    junk_r <= ~junk_r;
  end
  assign rdata_out = !oe_n_in ? mem_r[sel] : junk_r;
  assign ack_n_out = ((!oe_n_in || !we_n_in) && n_r >= ack_dly_in) ? 1'b0 : 1'b1;
endmodule

/* ebpi_top_tb_top.sv */
// self-checking bench of the external bus pin interface
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module ebpi_top_tb_top
  import ebpi_pkg::*;
;
  // ----------------------------------------
  // signals, design and device model
  // ----------------------------------------
  logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, hw = 1'b0, sbwe = 1'b0, io_and = 1'b1;
  logic [1:0] htr = 2'h0, sspd = 2'h0;
  logic [31:0] ha = 32'h0, hwd = 32'h0, hrd, din, dout, r;
  logic hrdy, ale_n, oe_n, we_n, doe, iso, ioclk, ack_n, doe_acc;
  logic [7:0] cs_n, cs_acc, ack_dly = 8'h00;
  logic [3:0] ln_n, ln_acc;
  logic [15:0] pa, hi;
  int error_cnt = 0, n_compared = 0, ale_cnt, stb, iso_lo;
  time t0;
  // write flag, offset, data or expected read value
  logic [40:0] rows [9] = '{{1'b1, 8'h04, 32'h1f}, {1'b0, 8'h04, 32'h1f}, {1'b1, 8'h04, 32'h0},
    {1'b0, 8'h00, 32'h1}, {1'b1, 8'h1c, 32'hffffffff}, {1'b0, 8'h1c, 32'h0},
    {1'b0, 8'h14, 32'h0}, {1'b1, 8'h08, 32'h89abcdef}, {1'b0, 8'h08, 32'h89abcdef}};
  ebpi_top u_ebpi_top (.CLK_IN(clk), .RESETN_IN(rst_n), .HSEL_IN(1'b1), .HADDR_IN(ha),
    .HTRANS_IN(htr), .HWRITE_IN(hw), .HSIZE_IN(3'h2), .HWDATA_IN(hwd), .HREADY_IN(hrdy),
    .HRDATA_OUT(hrd), .HREADYOUT_OUT(hrdy), .HRESP_OUT(), .LINK_CLK_IN(lclk),
    .STRAP_SPEED_IN(sspd), .STRAP_BWE_IN(sbwe), .IO_CLK_OUT(ioclk),
    .ADDRESS_LATCH_STROBE_N_OUT(ale_n), .ADDR_OUT(pa), .CHIP_SEL_N_OUT(cs_n),
    .OUT_EN_N_OUT(oe_n), .STATIC_WRITE_STROBE_N_OUT(we_n), .BYTE_LANE_N_OUT(ln_n),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_OUT(doe), .ACK_N_IN(ack_n),
    .BUS_ISOLATE_OUT(iso));
  ebpi_mem_model u_ebpi_mem_model (.link_clk_in(lclk), .cs_n_in(cs_n), .oe_n_in(oe_n),
    .we_n_in(we_n), .wdata_in(dout), .ack_dly_in(ack_dly), .rdata_out(din),
    .ack_n_out(ack_n));
  // clocks: the link clock is offset so the two never share an edge
  initial
    forever #20 clk = ~clk;
  initial
  begin
    #7;
    forever #16 lclk = ~lclk;
  end
  // pin monitor, sampled mid-cycle where the flops have settled
  always @(negedge lclk)
  begin
    if (!ale_n)
      ale_cnt++;
    if (!ale_n)
      hi = pa;
    cs_acc &= cs_n;
    ln_acc &= ln_n;
    io_and &= ioclk;
    doe_acc |= doe;
    if (!oe_n || !we_n)
      stb++;
    if (!iso)
      iso_lo++;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // ready is read at the falling edge so the rising edge never races the flop
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    @(posedge clk);
    ha <= {24'h0, a};
    hw <= w;
    htr <= 2'h2;
    do begin @(negedge clk); ok = hrdy; @(posedge clk); end while (ok !== 1'b1);
    htr <= 2'h0;
    hwd <= d;
    do begin @(negedge clk); ok = hrdy; r = hrd; @(posedge clk); end while (ok !== 1'b1);
  endtask
  task automatic rst(input logic [1:0] s, input logic b);
    @(posedge clk);
    rst_n <= 1'b0;
    sspd <= s;
    sbwe <= b;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge lclk);
  endtask
  // one external cycle; exn below zero means the strobe waits for acknowledge
  task automatic cyc(input logic [2:0] cs, input logic w, input logic [3:0] ln,
    input logic [31:0] a, input logic [31:0] d, input logic [3:0] exl, input int exn);
    bus(1'b1, 8'h08, a);
    bus(1'b1, 8'h0c, d);
    ale_cnt = 0;
    stb = 0;
    iso_lo = 0;
    cs_acc = 8'hff;
    ln_acc = 4'hf;
    doe_acc = 1'b0;
    bus(1'b1, 8'h10, {24'h0, ln, w, cs});
    r = 32'h0;
    repeat (40)
      if (r[1] !== 1'b1)
        bus(1'b0, 8'h14, 32'h0);
    `CHK(r[1:0], 2'h2)
    bus(1'b1, 8'h14, 32'h2);
    `CHK(cs_acc, ~(8'h01 << cs))
    `CHK(ale_cnt, 1)
    `CHK(hi, a[31:16])
    `CHK(ln_acc, exl)
    `CHK(doe_acc, w)
    `CHK(iso_lo > 0 && iso === 1'b1, 1'b1)
    if (exn < 0)
      `CHK(stb >= 6, 1'b1)
    else
      `CHK(stb, exn)
    if (!w && exl == 4'h0)
      bus(1'b0, 8'h18, 32'h0);
    if (!w && exl == 4'h0)
      `CHK(r, d)
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // sequence and watchdog
  // ----------------------------------------
  initial
  begin
    rst(2'h0, 1'b0);
    foreach (rows[i])
    begin
      bus(rows[i][40], rows[i][39:32], rows[i][31:0]);
      if (!rows[i][40])
        `CHK(r, rows[i][31:0])
    end
    bus(1'b1, 8'h00, 32'h0);
    repeat (4) @(posedge lclk);
    io_and = 1'b1;
    repeat (12) @(posedge lclk);
    `CHK(io_and, 1'b1)
    bus(1'b1, 8'h00, 32'h1);
    cyc(3'h3, 1'b1, 4'h9, 32'habcd0010, 32'h11223344, 4'h6, 2);
    cyc(3'h3, 1'b0, 4'hf, 32'habcd0010, 32'h11223344, 4'h0, 2);
    bus(1'b1, 8'h04, 32'h1);
    cyc(3'h3, 1'b0, 4'hf, 32'h00070000, 32'h0, 4'hc, 2);
    bus(1'b1, 8'h04, 32'h2);
    cyc(3'h3, 1'b0, 4'hf, 32'h00070000, 32'h0, 4'he, 2);
    bus(1'b1, 8'h04, 32'hc);
    cyc(3'h1, 1'b1, 4'h5, 32'h12340004, 32'hcafe0042, 4'ha, 2);
    cyc(3'h1, 1'b0, 4'hf, 32'h12340004, 32'h0, 4'hf, 2);
    bus(1'b1, 8'h04, 32'h10);
    ack_dly = 8'h06;
    cyc(3'h1, 1'b0, 4'hf, 32'h12340004, 32'hcafe0042, 4'h0, -1);
    for (int s = 3; s >= 0; s--)
    begin
      rst(2'(s), s[0]);
      bus(1'b0, 8'h00, 32'h0);
      `CHK(r, {28'h0, s[0], 2'(s), 1'b1})
      @(posedge ioclk);
      t0 = $time;
      @(posedge ioclk);
      `CHK($time - t0, 64'(32 * (s + 1)))
      // strap alone picks byte write mode here, so read lanes must stay high
      if (s == 1)
        cyc(3'h2, 1'b0, 4'hf, 32'h0, 32'h0, 4'hf, 2);
    end
    stop_test();
  end
  // the whole run takes well under a tenth of this span
  initial
  begin
    #500000;
    error_cnt++;
    stop_test();
  end
endmodule
